// ### rtl/dkc_dev.sv
// Controller-board end of the host port: hard-disk command interpreter
// with self-test, default geometry and sense data, plus an independent
// floppy byte channel served by host DMA. Assumes one sys_clk with the host.
//
// Contract
// - Hard-disk and floppy sections run independently.
// - Hard-disk data in words, floppy in bytes.
// - Floppy data moves over a DMA channel.
// - Host drives floppy hardware; no local control.
// - Reset lights fault LED, then runs diagnostics.
// - Code E4 runs the reset diagnostics.
// - Failed diagnostic leaves fault LED lit.
// - Disk commands rejected until diagnostics pass.
// - Diagnostics and sense stay usable after failure.
// - All pass clears LED, enables disk commands.
// - Reset loads heads default hex 03.
// - Cylinder MSB default hex 01.
// - Cylinder LSB default hex 31.
// - Reduced write current default hex 80.
// - Write precompensation default hex 80.
// - Defaults sit in Initialize list order.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module dkc_dev (
	input wire logic sys_clk,
	input wire logic rst_n,
	dkc_if.dev hp,
	input wire logic [2:0] diag_inject,
	output logic fault_led,
	output logic drive_act,
	output logic [7:0] geo_heads,
	output logic [7:0] geo_cyl_msb,
	output logic [7:0] geo_cyl_lsb,
	output logic [7:0] geo_rwc,
	output logic [7:0] geo_wpc,
	input wire logic fd_in_valid,
	input wire logic [7:0] fd_in_data,
	output logic fd_in_ready,
	output logic fd_out_valid,
	output logic [7:0] fd_out_data,
	input wire logic fd_out_ready
);
	typedef enum logic [5:0] {
		DKC_IDLE = 6'b000001,
		DKC_DIAG = 6'b000010,
		DKC_PARM = 6'b000100,
		DKC_DRV = 6'b001000,
		DKC_SENSE = 6'b010000,
		DKC_DONE = 6'b100000
	} dkc_state_t;

	dkc_state_t state_ff;
	dkc_state_t nxt_state;
	logic led_ff;
	logic passed_ff;
	logic diag_go_ff;
	logic cmd_rdy_ff;
	logic wd_rdy_ff;
	logic rd_vld_ff;
	logic [15:0] rd_dat_ff;
	logic done_ff;
	logic [7:0] sts_ff;
	logic [7:0] nxt_sts;
	logic [7:0] sense_ff;
	logic [1:0] pcnt_ff;
	logic [7:0] act_cnt_ff;
	logic drive_act_ff;
	localparam int PARM_BYTES_W = dkc_pkg::PARM_BYTES;
	localparam logic [7:0] PARM_DEF [PARM_BYTES_W] = '{dkc_pkg::DEF_HEADS,
		dkc_pkg::DEF_CYL_MSB, dkc_pkg::DEF_CYL_LSB, dkc_pkg::DEF_RWC, dkc_pkg::DEF_WPC};
	logic [7:0] parm_ff [PARM_BYTES_W];
	logic diag_busy;
	logic diag_fin;
	logic diag_pass;
	logic [7:0] diag_code;

	// Command decode
	wire cmd_take = hp.cmd_valid && cmd_rdy_ff;
	wire is_diag = (hp.cmd_code == dkc_pkg::CMD_DIAG);
	wire is_sense = (hp.cmd_code == dkc_pkg::CMD_SENSE);
	wire is_init = (hp.cmd_code == dkc_pkg::CMD_INIT);
	wire is_disk = !is_diag && !is_sense;
	wire reject = is_disk && !passed_ff;
	wire wd_take = hp.wd_valid && wd_rdy_ff;
	wire rd_take = rd_vld_ff && hp.rd_ready;
	wire act_end = (act_cnt_ff == dkc_pkg::DRV_CYC - 8'h01);
	wire parm_last = (pcnt_ff == dkc_pkg::PARM_WORDS - 2'h1);

	dkc_diag u_diag (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(diag_go_ff),
		.fail_inject(diag_inject),
		.busy(diag_busy),
		.fin(diag_fin),
		.pass(diag_pass),
		.fail_code(diag_code)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_sts = sts_ff;
		unique case (state_ff)
			DKC_IDLE: begin
				if (cmd_take) begin
					if (is_diag) begin
						nxt_state = DKC_DIAG;
					end else if (is_sense) begin
						nxt_state = DKC_SENSE;
					end else if (reject) begin
						nxt_sts = dkc_pkg::STS_REJECT;
						nxt_state = DKC_DONE;
					end else if (is_init) begin
						nxt_state = DKC_PARM;
					end else begin
						nxt_state = DKC_DRV;
					end
				end
			end
			DKC_DIAG: begin
				if (diag_fin) begin
					nxt_sts = diag_pass ? dkc_pkg::STS_OK : dkc_pkg::STS_DIAG_FAIL;
					nxt_state = DKC_DONE;
				end
			end
			DKC_PARM: begin
				if (wd_take && parm_last) begin
					nxt_sts = dkc_pkg::STS_OK;
					nxt_state = DKC_DONE;
				end
			end
			DKC_DRV: begin
				if (act_end) begin
					nxt_sts = dkc_pkg::STS_OK;
					nxt_state = DKC_DONE;
				end
			end
			DKC_SENSE: begin
				if (rd_take) begin
					nxt_sts = dkc_pkg::STS_OK;
					nxt_state = DKC_DONE;
				end
			end
			DKC_DONE: nxt_state = DKC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_ff <= DKC_DIAG;
			led_ff <= 1'b1;
			passed_ff <= 1'b0;
			diag_go_ff <= 1'b1;
			sts_ff <= dkc_pkg::STS_OK;
		end else begin
			state_ff <= nxt_state;
			sts_ff <= nxt_sts;
			diag_go_ff <= cmd_take && is_diag && (state_ff == DKC_IDLE);
			if (cmd_take && is_diag) begin
				led_ff <= 1'b1;
				passed_ff <= 1'b0;
			end else if (diag_fin) begin
				led_ff <= !diag_pass;
				passed_ff <= diag_pass;
			end
		end
	end

	// Host handshakes and sense data
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmd_rdy_ff <= 1'b0;
			wd_rdy_ff <= 1'b0;
			rd_vld_ff <= 1'b0;
			rd_dat_ff <= 16'h0000;
			done_ff <= 1'b0;
			sense_ff <= 8'h00;
			pcnt_ff <= 2'h0;
		end else begin
			cmd_rdy_ff <= (nxt_state == DKC_IDLE) && !cmd_take;
			wd_rdy_ff <= (nxt_state == DKC_PARM) && !(wd_take && parm_last);
			done_ff <= (nxt_state == DKC_DONE);
			if (diag_fin) begin
				sense_ff <= diag_code;
			end
			if (state_ff == DKC_IDLE && cmd_take && is_sense) begin
				rd_vld_ff <= 1'b1;
				rd_dat_ff <= {sts_ff, sense_ff};
			end else if (rd_take) begin
				rd_vld_ff <= 1'b0;
			end
			if (state_ff != DKC_PARM) begin
				pcnt_ff <= 2'h0;
			end else if (wd_take) begin
				pcnt_ff <= pcnt_ff + 2'h1;
			end
		end
	end

	// Drive activity only for accepted disk commands
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			drive_act_ff <= 1'b0;
			act_cnt_ff <= 8'h00;
		end else begin
			drive_act_ff <= (nxt_state == DKC_DRV);
			act_cnt_ff <= (state_ff == DKC_DRV) ? act_cnt_ff + 8'h01 : 8'h00;
		end
	end

	// Geometry bytes: low lane is the even list byte, high lane the odd one
	genvar gi;
	generate
		for (gi = 0; gi < PARM_BYTES_W; gi++) begin : g_parm
			wire hit = wd_take && (pcnt_ff == 2'(gi / 2));
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					parm_ff[gi] <= PARM_DEF[gi];
				end else if (hit) begin
					parm_ff[gi] <= (gi % 2 == 0) ? hp.wd_data[7:0] : hp.wd_data[15:8];
				end
			end
		end
	endgenerate

	// Floppy byte channel, independent of the self-test state
	logic fd_in_full_ff;
	logic [7:0] fd_in_ff;
	logic fd_out_full_ff;
	logic [7:0] fd_out_ff;
	logic fd_drq_ff;
	logic fd_in_rdy_ff;
	wire fd_ack = hp.fd_dack && fd_drq_ff;
	wire fd_load = fd_in_valid && fd_in_rdy_ff;
	wire fd_drain = fd_out_full_ff && fd_out_ready;
	wire nxt_in_full = fd_load || (fd_in_full_ff && !(fd_ack && !hp.fd_dir));
	wire nxt_out_full = (fd_ack && hp.fd_dir) || (fd_out_full_ff && !fd_drain);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fd_in_full_ff <= 1'b0;
			fd_in_ff <= 8'h00;
			fd_out_full_ff <= 1'b0;
			fd_out_ff <= 8'h00;
			fd_drq_ff <= 1'b0;
			fd_in_rdy_ff <= 1'b0;
		end else begin
			fd_in_full_ff <= nxt_in_full;
			fd_out_full_ff <= nxt_out_full;
			fd_in_rdy_ff <= !nxt_in_full;
			fd_drq_ff <= hp.fd_dir ? !nxt_out_full : nxt_in_full;
			if (fd_load) begin
				fd_in_ff <= fd_in_data;
			end
			if (fd_ack && hp.fd_dir) begin
				fd_out_ff <= hp.fd_h2d;
			end
		end
	end

	assign hp.cmd_ready = cmd_rdy_ff;
	assign hp.wd_ready = wd_rdy_ff;
	assign hp.rd_valid = rd_vld_ff;
	assign hp.rd_data = rd_dat_ff;
	assign hp.done = done_ff;
	assign hp.status = sts_ff;
	assign hp.fd_drq = fd_drq_ff;
	assign hp.fd_d2h = fd_in_ff;
	assign fault_led = led_ff;
	assign drive_act = drive_act_ff;
	assign geo_heads = parm_ff[0];
	assign geo_cyl_msb = parm_ff[1];
	assign geo_cyl_lsb = parm_ff[2];
	assign geo_rwc = parm_ff[3];
	assign geo_wpc = parm_ff[4];
	assign fd_in_ready = fd_in_rdy_ff;
	assign fd_out_valid = fd_out_full_ff;
	assign fd_out_data = fd_out_ff;
endmodule : dkc_dev

// ### rtl/dkc_diag.sv
// Built-in diagnostic sequencer: runs the tests one after another and
// stops at the first failure. Assumes start is a one-cycle pulse.
`timescale 1ns/1ps
module dkc_diag (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [2:0] fail_inject,
	output logic busy,
	output logic fin,
	output logic pass,
	output logic [7:0] fail_code
);
	logic busy_ff;
	logic fin_ff;
	logic pass_ff;
	logic [7:0] code_ff;
	logic [1:0] test_ff;
	logic [7:0] cnt_ff;
	wire test_end = busy_ff && (cnt_ff == dkc_pkg::DIAG_CYC - 8'h01);
	wire test_bad = fail_inject[test_ff];
	wire last_test = (test_ff == 2'(dkc_pkg::DIAG_TESTS - 1));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			fin_ff <= 1'b0;
			pass_ff <= 1'b0;
			code_ff <= 8'h00;
			test_ff <= 2'h0;
			cnt_ff <= 8'h00;
		end else begin
			fin_ff <= 1'b0;
			if (start) begin
				busy_ff <= 1'b1;
				pass_ff <= 1'b0;
				code_ff <= 8'h00;
				test_ff <= 2'h0;
				cnt_ff <= 8'h00;
			end else if (test_end) begin
				cnt_ff <= 8'h00;
				if (test_bad || last_test) begin
					busy_ff <= 1'b0;
					fin_ff <= 1'b1;
					pass_ff <= !test_bad;
					code_ff <= test_bad ? {6'h00, test_ff} + 8'h01 : 8'h00;
				end else begin
					test_ff <= test_ff + 2'h1;
				end
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	assign busy = busy_ff;
	assign fin = fin_ff;
	assign pass = pass_ff;
	assign fail_code = code_ff;
endmodule : dkc_diag

// ### rtl/dkc_host.sv
// Host end of the port: APB slave registers that issue commands, move
// hard-disk words, and run the floppy DMA channel; one level interrupt.
// Assumes the board end shares sys_clk.
`timescale 1ns/1ps
module dkc_host (
	input wire logic sys_clk,
	input wire logic rst_n,
	dkc_if.host hp,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic irq_ff;
	logic cmd_vld_ff;
	logic [7:0] cmd_ff;
	logic [7:0] sts_ff;
	logic wd_vld_ff;
	logic [15:0] wd_ff;
	logic rx_full_ff;
	logic [15:0] rx_ff;
	logic [1:0] fctrl_ff;
	logic fd_tx_full_ff;
	logic [7:0] fd_tx_ff;
	logic [7:0] fd_rx_ff;
	logic fd_dack_ff;
	logic [2:0] irq_sts_ff;
	logic [2:0] irq_mask_ff;
	logic [31:0] rd_mux;

	wire acc = psel && penable && !pready_ff;
	wire fin = psel && penable && pready_ff;
	wire wr = fin && pwrite;
	wire rd = fin && !pwrite;
	wire mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
	wire wr_cmd = wr && paddr == dkc_pkg::REG_CMD && !cmd_vld_ff;
	wire wr_wd = wr && paddr == dkc_pkg::REG_WDATA && !wd_vld_ff;
	wire rd_rx = rd && paddr == dkc_pkg::REG_RDATA;
	wire wr_fd = wr && paddr == dkc_pkg::REG_FDATA && !fd_tx_full_ff;
	wire rd_fd = rd && paddr == dkc_pkg::REG_FDATA;
	wire fd_en = fctrl_ff[dkc_pkg::FCTRL_EN];
	wire fd_dir = fctrl_ff[dkc_pkg::FCTRL_DIR];
	wire fd_go = fd_en && hp.fd_drq && !fd_dack_ff && (fd_dir ? fd_tx_full_ff : 1'b1);
	wire rx_take = hp.rd_valid && !rx_full_ff;
	wire [2:0] irq_set = {fd_dack_ff, rx_take, hp.done};
	wire [2:0] irq_clr = (wr && paddr == dkc_pkg::REG_IRQ_STS) ? pwdata[2:0] : 3'h0;

	always_comb begin
		unique case (paddr)
			dkc_pkg::REG_CMD: rd_mux = {23'h0, cmd_vld_ff, cmd_ff};
			dkc_pkg::REG_STAT: rd_mux = {24'h0, sts_ff};
			dkc_pkg::REG_WDATA: rd_mux = {15'h0, wd_vld_ff, wd_ff};
			dkc_pkg::REG_RDATA: rd_mux = {15'h0, rx_full_ff, rx_ff};
			dkc_pkg::REG_FCTRL: rd_mux = {30'h0, fctrl_ff};
			dkc_pkg::REG_FDATA: rd_mux = {23'h0, fd_tx_full_ff, fd_rx_ff};
			dkc_pkg::REG_IRQ_STS: rd_mux = {29'h0, irq_sts_ff};
			dkc_pkg::REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			irq_ff <= 1'b0;
			irq_sts_ff <= 3'h0;
			irq_mask_ff <= 3'h0;
			fctrl_ff <= 2'h0;
			sts_ff <= 8'h00;
		end else begin
			pready_ff <= acc;
			pslverr_ff <= acc && !mapped;
			prdata_ff <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
			irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_set;
			irq_ff <= |(((irq_sts_ff & ~irq_clr) | irq_set) & irq_mask_ff);
			if (wr && paddr == dkc_pkg::REG_IRQ_MASK) begin
				irq_mask_ff <= pwdata[2:0];
			end
			if (wr && paddr == dkc_pkg::REG_FCTRL) begin
				fctrl_ff <= pwdata[1:0];
			end
			if (hp.done) begin
				sts_ff <= hp.status;
			end
		end
	end

	// Hard-disk command and word transfers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmd_vld_ff <= 1'b0;
			cmd_ff <= 8'h00;
			wd_vld_ff <= 1'b0;
			wd_ff <= 16'h0000;
			rx_full_ff <= 1'b0;
			rx_ff <= 16'h0000;
		end else begin
			if (wr_cmd) begin
				cmd_vld_ff <= 1'b1;
				cmd_ff <= pwdata[7:0];
			end else if (hp.cmd_ready) begin
				cmd_vld_ff <= 1'b0;
			end
			if (wr_wd) begin
				wd_vld_ff <= 1'b1;
				wd_ff <= pwdata[15:0];
			end else if (hp.wd_ready) begin
				wd_vld_ff <= 1'b0;
			end
			if (rx_take) begin
				rx_full_ff <= 1'b1;
				rx_ff <= hp.rd_data;
			end else if (rd_rx) begin
				rx_full_ff <= 1'b0;
			end
		end
	end

	// Floppy DMA: one byte per acknowledge
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fd_dack_ff <= 1'b0;
			fd_tx_full_ff <= 1'b0;
			fd_tx_ff <= 8'h00;
			fd_rx_ff <= 8'h00;
		end else begin
			fd_dack_ff <= fd_go;
			if (wr_fd) begin
				fd_tx_full_ff <= 1'b1;
				fd_tx_ff <= pwdata[7:0];
			end else if (fd_dack_ff && fd_dir) begin
				fd_tx_full_ff <= 1'b0;
			end
			if (fd_go && !fd_dir) begin
				fd_rx_ff <= hp.fd_d2h;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	assign hp.cmd_valid = cmd_vld_ff;
	assign hp.cmd_code = cmd_ff;
	assign hp.wd_valid = wd_vld_ff;
	assign hp.wd_data = wd_ff;
	assign hp.rd_ready = !rx_full_ff;
	assign hp.fd_dir = fd_dir;
	assign hp.fd_dack = fd_dack_ff;
	assign hp.fd_h2d = fd_tx_ff;
endmodule : dkc_host

// ### rtl/dkc_if.sv
// Host port between the controller board and the host.
// Assumes both ends run on the same sys_clk; all signals are levels
// except fd_dack and done, which are one-cycle pulses.
`timescale 1ns/1ps
interface dkc_if;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic cmd_ready;
	logic wd_valid;
	logic [15:0] wd_data;
	logic wd_ready;
	logic rd_valid;
	logic [15:0] rd_data;
	logic rd_ready;
	logic done;
	logic [7:0] status;
	logic fd_dir;
	logic fd_drq;
	logic fd_dack;
	logic [7:0] fd_h2d;
	logic [7:0] fd_d2h;
	modport dev (
		input cmd_valid, cmd_code, wd_valid, wd_data, rd_ready, fd_dir, fd_dack, fd_h2d,
		output cmd_ready, wd_ready, rd_valid, rd_data, done, status, fd_drq, fd_d2h
	);
	modport host (
		output cmd_valid, cmd_code, wd_valid, wd_data, rd_ready, fd_dir, fd_dack, fd_h2d,
		input cmd_ready, wd_ready, rd_valid, rd_data, done, status, fd_drq, fd_d2h
	);
endinterface : dkc_if

// ### rtl/dkc_pkg.sv
// Shared constants for the disk controller host port: command codes,
// completion codes, default geometry, timing counts and host register map.
// Assumes both ends, the checker and the testbench use these names.
package dkc_pkg;
	// Command codes
	localparam logic [7:0] CMD_DIAG = 8'hE4;
	localparam logic [7:0] CMD_SENSE = 8'h03;
	localparam logic [7:0] CMD_INIT = 8'h0C;
	// Completion status
	localparam logic [7:0] STS_OK = 8'h00;
	localparam logic [7:0] STS_REJECT = 8'h01;
	localparam logic [7:0] STS_DIAG_FAIL = 8'h02;
	// Default geometry, in Initialize parameter-list order
	localparam logic [7:0] DEF_HEADS = 8'h03;
	localparam logic [7:0] DEF_CYL_MSB = 8'h01;
	localparam logic [7:0] DEF_CYL_LSB = 8'h31;
	localparam logic [7:0] DEF_RWC = 8'h80;
	localparam logic [7:0] DEF_WPC = 8'h80;
	localparam int PARM_BYTES = 5;
	localparam logic [1:0] PARM_WORDS = 2'h3;
	// Timing counts in sys_clk cycles, and the number of self-tests
	localparam logic [7:0] DIAG_CYC = 8'h10;
	localparam logic [7:0] DRV_CYC = 8'h08;
	localparam int DIAG_TESTS = 3;
	// Host register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_FCTRL = 8'h10;
	localparam logic [7:0] REG_FDATA = 8'h14;
	localparam logic [7:0] REG_IRQ_STS = 8'h18;
	localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
	// Interrupt status bit positions and field width
	localparam int IRQ_DONE = 0;
	localparam int IRQ_HD_RX = 1;
	localparam int IRQ_FD = 2;
	localparam int IRQ_W = 3;
	// Floppy control bit positions
	localparam int FCTRL_DIR = 0;
	localparam int FCTRL_EN = 1;
endpackage : dkc_pkg

// ### verif/dkc_sva.sv
// Checker for the host port that joins the board end and the host end.
// Assumes one sys_clk and a synchronous active-low rst_n on both ends.
`timescale 1ns/1ps
module dkc_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_ready,
	input wire logic done,
	input wire logic [7:0] status,
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	input wire logic fd_drq,
	input wire logic fd_dack
);
	logic diag_ok_ff;
	logic last_diag_ff;
	wire logic take = cmd_valid && cmd_ready;
	wire logic take_diag = take && cmd_code == dkc_pkg::CMD_DIAG;
	wire logic take_disk = take && !take_diag && cmd_code != dkc_pkg::CMD_SENSE;
	wire logic diag_end = done && last_diag_ff;
	wire logic nxt_last_diag = take ? take_diag : last_diag_ff;
	// Remembers whether the latest finished self-test passed
	wire logic nxt_diag_ok = take_diag ? 1'b0 :
		diag_end ? status == dkc_pkg::STS_OK : diag_ok_ff;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			diag_ok_ff <= 1'b0;
			last_diag_ff <= 1'b1;
		end else begin
			diag_ok_ff <= nxt_diag_ok;
			last_diag_ff <= nxt_last_diag;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_reject;
		done && status == dkc_pkg::STS_REJECT;
	endsequence
	sequence s_diag_run;
		(!done)[*8] ##[11:43] (done && (status == dkc_pkg::STS_OK ||
			status == dkc_pkg::STS_DIAG_FAIL));
	endsequence
	sequence s_drive_run;
		(!done)[*8] ##[1:5] (done && status == dkc_pkg::STS_OK);
	endsequence
	property p_reject;
		take_disk && !diag_ok_ff |=> s_reject;
	endproperty
	a_reject: assert property (p_reject) else $error("disk command not rejected");
	property p_disk_run;
		take_disk && diag_ok_ff && cmd_code != dkc_pkg::CMD_INIT |=> s_drive_run;
	endproperty
	a_disk_run: assert property (p_disk_run) else $error("disk command not run");
	property p_diag_run;
		take_diag |=> s_diag_run;
	endproperty
	a_diag_run: assert property (p_diag_run) else $error("self-test length wrong");
	property p_busy;
		take |=> !cmd_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_done_pulse;
		done |=> !done && cmd_ready;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not followed by idle");
	property p_status_hold;
		!$stable(status) |-> done;
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status moved without done");
	property p_sense_word;
		rd_valid |-> rd_data[7:0] <= 8'h03;
	endproperty
	a_sense_word: assert property (p_sense_word) else $error("bad failing test number");
	property p_drq_drop;
		fd_dack && fd_drq |=> !fd_drq;
	endproperty
	a_drq_drop: assert property (p_drq_drop) else $error("request held after byte");
	property p_dack_gap;
		fd_dack |=> !fd_dack;
	endproperty
	a_dack_gap: assert property (p_dack_gap) else $error("acknowledges back to back");
endmodule : dkc_sva

// ### verif/dkc_tb.sv
// Testbench: both ends joined by the carrier, host end driven over APB.
// Assumes the package register map and a 50 ns sys_clk.
`timescale 1ns/1ps
module dkc_tb;
	logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, st;
	logic [2:0] diag_inject;
	logic fault_led, drive_act, fd_in_valid, fd_in_ready, fd_out_valid, fd_out_ready;
	logic [7:0] g_h, g_m, g_l, g_r, g_w, fd_in_data, fd_out_data, out_byte;
	logic act_seen, out_seen;
	int err_total, tests_run;
	dkc_if hp ();
	dkc_dev dkc_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .hp(hp), .diag_inject(diag_inject),
		.fault_led(fault_led), .drive_act(drive_act), .geo_heads(g_h), .geo_cyl_msb(g_m),
		.geo_cyl_lsb(g_l), .geo_rwc(g_r), .geo_wpc(g_w), .fd_in_valid(fd_in_valid),
		.fd_in_data(fd_in_data), .fd_in_ready(fd_in_ready), .fd_out_valid(fd_out_valid),
		.fd_out_data(fd_out_data), .fd_out_ready(fd_out_ready));
	dkc_host dkc_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .hp(hp), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));
	dkc_sva dkc_sva_i (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(hp.cmd_valid),
		.cmd_code(hp.cmd_code), .cmd_ready(hp.cmd_ready), .done(hp.done), .status(hp.status),
		.rd_valid(hp.rd_valid), .rd_data(hp.rd_data), .fd_drq(hp.fd_drq), .fd_dack(hp.fd_dack));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (drive_act === 1'b1) act_seen <= 1'b1;
		if (fd_out_valid === 1'b1) begin
			out_byte <= fd_out_data;
			out_seen <= 1'b1;
		end
	end
	task automatic close_out;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	task automatic give_up;
		err_total++;
		$display("wrong value at %0t: wait ran out", $time);
		close_out;
	endtask : give_up
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk32
	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) give_up;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask : rd
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int n;
		logic [31:0] q;
		n = 0;
		do begin
			rd(a, q);
			n++;
		end while (q[b] !== v && n < 200);
		if (q[b] !== v) give_up;
	endtask : poll
	task automatic cmd_wait(output logic [31:0] s);
		poll(dkc_pkg::REG_IRQ_STS, dkc_pkg::IRQ_DONE, 1'b1);
		wr(dkc_pkg::REG_IRQ_STS, 32'h1);
		rd(dkc_pkg::REG_STAT, s);
	endtask : cmd_wait
	task automatic run_cmd(input logic [7:0] c, input logic [7:0] exp);
		logic [31:0] s;
		wr(dkc_pkg::REG_CMD, {24'h0, c});
		cmd_wait(s);
		chk32(s, {24'h0, exp});
	endtask : run_cmd
	task automatic t_reset;
		@(negedge sys_clk);
		chk1(fault_led, 1'b1);
		chk32({24'h0, g_h}, {24'h0, dkc_pkg::DEF_HEADS});
		chk32({24'h0, g_m}, {24'h0, dkc_pkg::DEF_CYL_MSB});
		chk32({24'h0, g_l}, {24'h0, dkc_pkg::DEF_CYL_LSB});
		chk32({24'h0, g_r}, {24'h0, dkc_pkg::DEF_RWC});
		chk32({24'h0, g_w}, {24'h0, dkc_pkg::DEF_WPC});
		cmd_wait(st);
		chk32(st, {24'h0, dkc_pkg::STS_DIAG_FAIL});
		chk1(fault_led, 1'b1);
		$display("reset test done");
	endtask : t_reset
	task automatic t_reject;
		act_seen = 1'b0;
		run_cmd(8'h20, dkc_pkg::STS_REJECT);
		run_cmd(dkc_pkg::CMD_INIT, dkc_pkg::STS_REJECT);
		chk1(act_seen, 1'b0);
		$display("reject test done");
	endtask : t_reject
	task automatic t_sense;
		diag_inject <= 3'b010;
		run_cmd(dkc_pkg::CMD_DIAG, dkc_pkg::STS_DIAG_FAIL);
		wr(dkc_pkg::REG_CMD, {24'h0, dkc_pkg::CMD_SENSE});
		cmd_wait(st);
		chk32(st, {24'h0, dkc_pkg::STS_OK});
		rd(dkc_pkg::REG_RDATA, st);
		chk32(st, {15'h0, 1'b1, dkc_pkg::STS_DIAG_FAIL, 8'h02});
		$display("sense test done");
	endtask : t_sense
	task automatic t_pass;
		diag_inject <= 3'b000;
		run_cmd(dkc_pkg::CMD_DIAG, dkc_pkg::STS_OK);
		chk1(fault_led, 1'b0);
		act_seen = 1'b0;
		wr(dkc_pkg::REG_CMD, 32'h20);
		poll(dkc_pkg::REG_IRQ_STS, dkc_pkg::IRQ_DONE, 1'b1);
		chk1(irq, 1'b0);
		cmd_wait(st);
		chk32(st, {24'h0, dkc_pkg::STS_OK});
		chk1(act_seen, 1'b1);
		$display("pass test done");
	endtask : t_pass
	task automatic t_init;
		wr(dkc_pkg::REG_CMD, {24'h0, dkc_pkg::CMD_INIT});
		poll(dkc_pkg::REG_WDATA, 16, 1'b0);
		wr(dkc_pkg::REG_WDATA, 32'h0207);
		poll(dkc_pkg::REG_WDATA, 16, 1'b0);
		wr(dkc_pkg::REG_WDATA, 32'h4064);
		poll(dkc_pkg::REG_WDATA, 16, 1'b0);
		wr(dkc_pkg::REG_WDATA, 32'hFF20);
		cmd_wait(st);
		chk32(st, {24'h0, dkc_pkg::STS_OK});
		chk32({g_h, g_m, g_l, g_r}, 32'h07026440);
		chk32({24'h0, g_w}, 32'h20);
		$display("init test done");
	endtask : t_init
	task automatic t_irq;
		logic e;
		wr(dkc_pkg::REG_IRQ_MASK, 32'h1);
		wr(dkc_pkg::REG_CMD, 32'h21);
		poll(dkc_pkg::REG_IRQ_STS, dkc_pkg::IRQ_DONE, 1'b1);
		@(negedge sys_clk);
		chk1(irq, 1'b1);
		wr(dkc_pkg::REG_IRQ_STS, 32'h1);
		@(negedge sys_clk);
		chk1(irq, 1'b0);
		wr(dkc_pkg::REG_IRQ_MASK, 32'h0);
		apb(1'b0, 8'h20, 32'h0, st, e);
		chk1(e, 1'b1);
		apb(1'b1, 8'h02, 32'h0, st, e);
		chk1(e, 1'b1);
		$display("interrupt test done");
	endtask : t_irq
	task automatic t_floppy;
		int n;
		// Disk command left running while the host moves floppy bytes
		wr(dkc_pkg::REG_CMD, 32'h20);
		wr(dkc_pkg::REG_FCTRL, 32'h2);
		@(posedge sys_clk);
		fd_in_valid <= 1'b1;
		fd_in_data <= 8'hA5;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (fd_in_ready !== 1'b1 && n < 50);
		if (fd_in_ready !== 1'b1) give_up;
		fd_in_valid <= 1'b0;
		poll(dkc_pkg::REG_IRQ_STS, dkc_pkg::IRQ_FD, 1'b1);
		rd(dkc_pkg::REG_FDATA, st);
		chk32({24'h0, st[7:0]}, 32'hA5);
		wr(dkc_pkg::REG_IRQ_STS, 32'h4);
		wr(dkc_pkg::REG_FCTRL, 32'h3);
		out_seen = 1'b0;
		wr(dkc_pkg::REG_FDATA, 32'h5A);
		n = 0;
		while (out_seen !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		if (out_seen !== 1'b1) give_up;
		chk32({24'h0, out_byte}, 32'h5A);
		cmd_wait(st);
		chk32(st, {24'h0, dkc_pkg::STS_OK});
		$display("floppy test done");
	endtask : t_floppy
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		diag_inject = 3'b001;
		fd_in_valid = 1'b0;
		fd_in_data = 8'h00;
		fd_out_ready = 1'b1;
		act_seen = 1'b0;
		out_seen = 1'b0;
		err_total = 0;
		tests_run = 0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_reject;
		t_sense;
		t_pass;
		t_init;
		t_irq;
		t_floppy;
		close_out;
	end
endmodule : dkc_tb
